// *** flash_host.sv ***
// host controller sequencing reads, writes and flash command sequences
// assumes a single flash part on the pins; no clock on the flash side
`timescale 1ns/100ps
`default_nettype none
module flash_host (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // user request
    input wire logic req_valid,
    input wire flash_host_pkg::req_t req,
    output logic req_ready,
    // user answer
    output logic rsp_valid,
    output logic [flash_host_pkg::DATA_W-1:0] rsp_data,
    output logic autoselect_active,
    output logic timeout_seen,
    // flash pins
    output logic chip_en_n,
    output logic out_en_n,
    output logic write_en_n,
    output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] data_bus_in,
    output logic [flash_host_pkg::DATA_W-1:0] data_bus_out,
    output logic data_bus_oe
);
    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_SEQ = 4'b0010,
        H_WAIT = 4'b0100,
        H_DONE = 4'b1000
    } h_state_t;
    h_state_t state_r, state_nxt;
    flash_host_pkg::req_t cur_r, cur_nxt;
    logic [1:0] step_r, step_nxt;
    logic asel_r, asel_nxt;
    logic tmo_r, tmo_nxt;
    logic [flash_host_pkg::DATA_W-1:0] data_r, data_nxt;
    logic rsp_r, rsp_nxt;
    logic cyc_start, cyc_wr, cyc_done;
    logic [flash_host_pkg::ADDR_W-1:0] cyc_addr;
    logic [flash_host_pkg::DATA_W-1:0] cyc_wdata, cyc_rdata;
    flash_host_pkg::pins_t pins;

    // index of the last bus cycle for each operation, counted from 0 like the current one
    function automatic logic [1:0] last_step(input flash_host_pkg::op_t op);
        case (op)
            flash_host_pkg::OP_AUTOSEL: last_step = 2'd2;
            default: last_step = 2'd0;
        endcase
    endfunction

    always_comb begin
        cyc_wr = 1'b0;
        cyc_addr = cur_r.addr;
        cyc_wdata = cur_r.data;
        case (cur_r.op)
            flash_host_pkg::OP_WRITE: cyc_wr = 1'b1;
            flash_host_pkg::OP_RESET: begin
                cyc_wr = 1'b1;
                cyc_wdata = flash_host_pkg::RESET_CMD;
            end
            flash_host_pkg::OP_AUTOSEL: begin
                cyc_wr = 1'b1;
                case (step_r)
                    2'd0: begin
                        cyc_addr = flash_host_pkg::UNLOCK1_ADDR;
                        cyc_wdata = flash_host_pkg::UNLOCK1_DATA;
                    end
                    2'd1: begin
                        cyc_addr = flash_host_pkg::UNLOCK2_ADDR;
                        cyc_wdata = flash_host_pkg::UNLOCK2_DATA;
                    end
                    default: begin
                        cyc_addr = flash_host_pkg::UNLOCK1_ADDR;
                        cyc_wdata = flash_host_pkg::AUTOSEL_CMD;
                    end
                endcase
            end
            flash_host_pkg::OP_ID_MAKER:
                cyc_addr = {cur_r.addr[flash_host_pkg::ADDR_W-1:8],
                            flash_host_pkg::ID_MAKER_OFS};
            flash_host_pkg::OP_ID_PART:
                cyc_addr = {cur_r.addr[flash_host_pkg::ADDR_W-1:8],
                            flash_host_pkg::ID_PART_OFS};
            flash_host_pkg::OP_ID_PROT:
                cyc_addr = flash_host_pkg::sector_base(
                    cur_r.addr[flash_host_pkg::SECTOR_LSB +:
                               flash_host_pkg::SECTOR_W])
                    | {11'h000, flash_host_pkg::ID_PROT_OFS};
            default: cyc_addr = cur_r.addr;
        endcase
    end

    assign cyc_start = (state_r == H_SEQ);

    always_comb begin
        state_nxt = state_r;
        cur_nxt = cur_r;
        step_nxt = step_r;
        asel_nxt = asel_r;
        tmo_nxt = tmo_r;
        data_nxt = data_r;
        rsp_nxt = 1'b0;
        case (state_r)
            H_IDLE: begin
                if (req_valid) begin
                    cur_nxt = req;
                    step_nxt = 2'd0;
                    state_nxt = H_SEQ;
                end
            end
            H_SEQ: state_nxt = H_WAIT;
            H_WAIT: begin
                if (cyc_done) begin
                    if (step_r == last_step(cur_r.op)) begin
                        state_nxt = H_DONE;
                    end else begin
                        step_nxt = step_r + 2'd1;
                        state_nxt = H_SEQ;
                    end
                end
            end
            H_DONE: begin
                rsp_nxt = 1'b1;
                data_nxt = cyc_rdata;
                case (cur_r.op)
                    flash_host_pkg::OP_AUTOSEL: asel_nxt = 1'b1;
                    flash_host_pkg::OP_RESET: begin
                        asel_nxt = 1'b0;
                        tmo_nxt = 1'b0;
                    end
                    // any other write leaves autoselect
                    flash_host_pkg::OP_WRITE: asel_nxt = 1'b0;
                    flash_host_pkg::OP_READ:
                        if (cyc_rdata[flash_host_pkg::TIMEOUT_FLAG_BIT])
                            tmo_nxt = 1'b1;
                    default: asel_nxt = asel_r;
                endcase
                state_nxt = H_IDLE;
            end
            default: state_nxt = H_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= H_IDLE;
            cur_r <= '0;
            step_r <= 2'd0;
            asel_r <= 1'b0;
            tmo_r <= 1'b0;
            data_r <= '0;
            rsp_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cur_r <= cur_nxt;
            step_r <= step_nxt;
            asel_r <= asel_nxt;
            tmo_r <= tmo_nxt;
            data_r <= data_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    bus_cycle u_cycle (
        .clk(clk),
        .rst_n(rst_n),
        .start(cyc_start),
        .is_write(cyc_wr),
        .addr(cyc_addr),
        .wdata(cyc_wdata),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .pins(pins),
        .data_bus_in(data_bus_in)
    );

    assign req_ready = (state_r == H_IDLE);
    assign rsp_valid = rsp_r;
    assign rsp_data = data_r;
    assign autoselect_active = asel_r;
    assign timeout_seen = tmo_r;
    assign chip_en_n = pins.ce_n;
    assign out_en_n = pins.oe_n;
    assign write_en_n = pins.we_n;
    assign flash_addr = pins.addr;
    assign data_bus_out = pins.dout;
    assign data_bus_oe = pins.doe;

    AST_AUTOSEL_SEQ: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == H_DONE && cur_r.op == flash_host_pkg::OP_AUTOSEL)
        |=> asel_r)
        else $error("autoselect flag not set after sequence");
    AST_RESET_EXIT: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == H_DONE && cur_r.op == flash_host_pkg::OP_RESET)
        |=> (!asel_r && !tmo_r))
        else $error("reset command did not clear mode");
    AST_ASEL_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(asel_r)) |-> $past(cur_r.op) inside
        {flash_host_pkg::OP_RESET, flash_host_pkg::OP_WRITE})
        else $error("autoselect left without a write");
    AST_PROT_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
        (cyc_start && cur_r.op == flash_host_pkg::OP_ID_PROT)
        |-> cyc_addr[7:0] == flash_host_pkg::ID_PROT_OFS)
        else $error("protection read at wrong low address");
    AST_ID_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
        (cyc_start && cur_r.op == flash_host_pkg::OP_ID_PART)
        |-> cyc_addr[7:0] == flash_host_pkg::ID_PART_OFS)
        else $error("part code read at wrong address");
    AST_READY_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        rsp_r |-> req_ready)
        else $error("controller stuck after answer");
    AST_CE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == H_IDLE) |-> (chip_en_n && !data_bus_oe))
        else $error("flash selected while idle");
    AST_TMO_SET: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == H_DONE && cur_r.op == flash_host_pkg::OP_READ
         && cyc_rdata[flash_host_pkg::TIMEOUT_FLAG_BIT]) |=> tmo_r)
        else $error("timeout flag missed");
    COV_READ: cover property (@(posedge clk)
        rsp_r && cur_r.op == flash_host_pkg::OP_READ);
    COV_ASEL: cover property (@(posedge clk) $rose(asel_r));
    COV_RESET: cover property (@(posedge clk) $fell(asel_r));
    COV_TMO: cover property (@(posedge clk) $rose(tmo_r));
endmodule // flash_host
`default_nettype wire

// *** flash_host_pkg.sv ***
// constants and types for the parallel flash host controller
// assumes a byte-wide asynchronous flash with unlock-style command sequences
package flash_host_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 10;
    // access time before read data is valid, and write pulse widths
    localparam int ACCESS_NS = 55;
    localparam int WR_PULSE_NS = 30;
    localparam int SETUP_NS = 10;
    localparam int ACCESS_CYC =
        (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_PULSE_CYC =
        (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    // command sequence addresses and data
    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h0_0555;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h0_02AA;
    localparam logic [DATA_W-1:0] UNLOCK1_DATA = 8'hAA;
    localparam logic [DATA_W-1:0] UNLOCK2_DATA = 8'h55;
    localparam logic [DATA_W-1:0] AUTOSEL_CMD = 8'h90;
    localparam logic [DATA_W-1:0] RESET_CMD = 8'hF0;
    // autoselect low-address offsets
    localparam logic [7:0] ID_MAKER_OFS = 8'h00;
    localparam logic [7:0] ID_PART_OFS = 8'h01;
    localparam logic [7:0] ID_PROT_OFS = 8'h02;
    localparam int SECTOR_LSB = 16;
    // position of the timeout flag in read data
    localparam int TIMEOUT_FLAG_BIT = 5;
    localparam int SECTOR_W = 3;
    // host operations
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_RESET = 3'h2,
        OP_AUTOSEL = 3'h3,
        OP_ID_MAKER = 3'h4,
        OP_ID_PART = 3'h5,
        OP_ID_PROT = 3'h6
    } op_t;
    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } req_t;
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic doe;
    } pins_t;
    function automatic logic [ADDR_W-1:0] sector_base(
        input logic [SECTOR_W-1:0] s);
        sector_base = {s, 16'h0000};
    endfunction
endpackage

// *** bus_cycle.sv ***
// one flash bus cycle (read or write) with timed strobes
// assumes the caller holds the request stable while busy
`timescale 1ns/100ps
`default_nettype none
module bus_cycle (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // cycle request
    input wire logic start,
    input wire logic is_write,
    input wire logic [flash_host_pkg::ADDR_W-1:0] addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] wdata,
    output logic done,
    output logic [flash_host_pkg::DATA_W-1:0] rdata,
    // flash pins
    output flash_host_pkg::pins_t pins,
    input wire logic [flash_host_pkg::DATA_W-1:0] data_bus_in
);
    typedef enum logic [3:0] {
        BC_IDLE = 4'b0001,
        BC_SETUP = 4'b0010,
        BC_STROBE = 4'b0100,
        BC_HOLD = 4'b1000
    } bc_state_t;
    bc_state_t state_r, state_nxt;
    logic [flash_host_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic wr_r, wr_nxt;
    flash_host_pkg::pins_t pins_r, pins_nxt;
    logic [flash_host_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
    logic [flash_host_pkg::DATA_W-1:0] sync1_r, sync2_r;
    logic done_r, done_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        pins_nxt = pins_r;
        rdata_nxt = rdata_r;
        done_nxt = 1'b0;
        case (state_r)
            BC_IDLE: begin
                if (start) begin
                    wr_nxt = is_write;
                    pins_nxt.addr = addr;
                    pins_nxt.dout = wdata;
                    pins_nxt.ce_n = 1'b0;
                    pins_nxt.oe_n = 1'b1;
                    pins_nxt.doe = is_write;
                    cnt_nxt =
                        flash_host_pkg::CNT_W'(flash_host_pkg::SETUP_CYC);
                    state_nxt = BC_SETUP;
                end
            end
            BC_SETUP: begin
                if (cnt_r <= 1) begin
                    if (wr_r) begin
                        pins_nxt.we_n = 1'b0;
                        cnt_nxt = flash_host_pkg::CNT_W'(
                            flash_host_pkg::WR_PULSE_CYC);
                    end else begin
                        pins_nxt.oe_n = 1'b0;
                        // two sync stages add to the access wait
                        cnt_nxt = flash_host_pkg::CNT_W'(
                            flash_host_pkg::ACCESS_CYC + 2);
                    end
                    state_nxt = BC_STROBE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            BC_STROBE: begin
                if (cnt_r <= 1) begin
                    // write strobe rises first: data taken there
                    pins_nxt.we_n = 1'b1;
                    pins_nxt.oe_n = 1'b1;
                    if (!wr_r)
                        rdata_nxt = sync2_r;
                    state_nxt = BC_HOLD;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            BC_HOLD: begin
                pins_nxt.ce_n = 1'b1;
                pins_nxt.doe = 1'b0;
                done_nxt = 1'b1;
                state_nxt = BC_IDLE;
            end
            default: state_nxt = BC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= BC_IDLE;
            cnt_r <= '0;
            wr_r <= 1'b0;
            pins_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0,
                        dout: '0, doe: 1'b0};
            rdata_r <= '0;
            done_r <= 1'b0;
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            pins_r <= pins_nxt;
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
            sync1_r <= data_bus_in;
            sync2_r <= sync1_r;
        end
    end

    assign pins = pins_r;
    assign rdata = rdata_r;
    assign done = done_r;

    AST_WE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(pins_r.we_n) |-> (!pins_r.we_n)[*3])
        else $error("write strobe pulse too short");
    AST_WR_QUAL: assert property (@(posedge clk) disable iff (!rst_n)
        !pins_r.we_n |-> (!pins_r.ce_n && pins_r.oe_n))
        else $error("write strobe without chip enable or with oe");
    AST_OE_WE: assert property (@(posedge clk) disable iff (!rst_n)
        !(!pins_r.oe_n && !pins_r.we_n))
        else $error("oe and we low together");
    AST_DRIVE_OE: assert property (@(posedge clk) disable iff (!rst_n)
        !pins_r.oe_n |-> !pins_r.doe)
        else $error("host drives bus while flash outputs");
endmodule // bus_cycle
`default_nettype wire

// *** flash_model.sv ***
// behavioural byte-wide flash: array read, unlock commands, autoselect
// assumes the bench resolves the shared data bus from both drivers
`timescale 1ns/100ps
`default_nettype none
module flash_model #(
    parameter logic [7:0] MAKER_CODE = 8'h1C, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h4E, // arbitrary value
    parameter logic [7:0] PROT_BITS = 8'h00
) (
    // strobes and address
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [18:0] addr,
    // data bus
    input wire logic [7:0] din,
    output logic [7:0] dout,
    output logic drive
);
    logic [1:0] st = 2'd0;
    logic [18:0] a_lat = '0;
    logic [18:0] a_d;
    logic rd_d;
    logic [7:0] val;
    realtime t_wr = 0.0;
    wire wr = !ce_n && !we_n && oe_n;
    wire rd = !ce_n && !oe_n && we_n;
    wire u1 = a_lat == flash_host_pkg::UNLOCK1_ADDR
        && din == flash_host_pkg::UNLOCK1_DATA;
    wire u2 = a_lat == flash_host_pkg::UNLOCK2_ADDR
        && din == flash_host_pkg::UNLOCK2_DATA;
    wire u3 = a_lat == flash_host_pkg::UNLOCK1_ADDR
        && din == flash_host_pkg::AUTOSEL_CMD;
    always @(posedge wr) begin
        a_lat = addr;
        t_wr = $realtime;
    end
    // command decode on the end of the write pulse
    always @(negedge wr) begin
        // a pulse whose start was never seen (power-up) is not a command
        if (t_wr > 0.0 && $realtime - t_wr >= 5.0) begin
            if (din == flash_host_pkg::RESET_CMD) begin
                st = 2'd0;
            end else begin
                case (st)
                2'd0: st = u1 ? 2'd1 : 2'd0;
                2'd1: st = u2 ? 2'd2 : 2'd0;
                2'd2: st = u3 ? 2'd3 : 2'd0;
                default: st = st;
                endcase
            end
        end
    end
    always_comb begin
        val = addr[7:0] ^ addr[15:8] ^ {5'h00, addr[18:16]};
        if (st == 2'd3) begin
            case (addr[7:0])
            8'h00: val = MAKER_CODE;
            8'h01: val = PART_CODE;
            8'h02: val = {7'h00, PROT_BITS[addr[18:16]]};
            default: val = 8'h00;
            endcase
        end
    end
    assign #(flash_host_pkg::ACCESS_NS) a_d = addr;
    assign #(flash_host_pkg::ACCESS_NS) rd_d = rd;
    wire ok = rd && rd_d && a_d == addr;
    assign drive = rd;
    assign dout = ok ? val : ~val;
endmodule // flash_model
`default_nettype wire

// *** flash_host_test.sv ***
// self-checking bench for the flash host controller with a flash model
// assumes the design package and the flash model are compiled first
`timescale 1ns/100ps
`default_nettype none
module flash_host_test;
    localparam logic [7:0] MAKER = 8'h1C; // arbitrary value
    localparam logic [7:0] PART = 8'h4E; // arbitrary value
    localparam logic [7:0] PROT = 8'h24;
    localparam logic [18:0] CORNER [5] = '{19'h0_FFFF, 19'h1_0000,
        19'h7_FFFF, 19'h0_0000, 19'h0_0020};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    flash_host_pkg::req_t req = '0;
    logic req_ready, rsp_valid, as_act, to_seen, ce_n, oe_n, we_n, doe, drv;
    logic [18:0] f_addr;
    logic [7:0] rsp_data, dbo, dbi, m_dout, got;
    logic exp_to = 1'b0;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    assign dbi = drv ? m_dout : (doe ? dbo : ~m_dout);
    flash_host i_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .autoselect_active(as_act),
        .timeout_seen(to_seen), .chip_en_n(ce_n), .out_en_n(oe_n),
        .write_en_n(we_n), .flash_addr(f_addr), .data_bus_in(dbi),
        .data_bus_out(dbo), .data_bus_oe(doe));
    flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .PROT_BITS(PROT))
    i_flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr),
        .din(dbi), .dout(m_dout), .drive(drv));
    function automatic logic [7:0] arr(input logic [18:0] a);
        return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]};
    endfunction
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic op(input flash_host_pkg::op_t o, input logic [18:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req = '{op: o, addr: a, data: d};
        // ready looked at mid-cycle, before the edge that takes the request
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100) begin
            check(8'h00, 8'hFF);
        end
        got = rsp_data;
        @(negedge clk);
    endtask
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        op(flash_host_pkg::OP_WRITE, a, d);
    endtask
    task automatic unl(input logic [7:0] d3);
        wr(flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA);
        wr(flash_host_pkg::UNLOCK2_ADDR, flash_host_pkg::UNLOCK2_DATA);
        wr(flash_host_pkg::UNLOCK1_ADDR, d3);
    endtask
    task automatic rd_chk(input logic [18:0] a);
        logic [7:0] e;
        e = arr(a);
        op(flash_host_pkg::OP_READ, a, 8'h00);
        check(got, e);
        exp_to = exp_to | e[flash_host_pkg::TIMEOUT_FLAG_BIT];
        check({7'h00, to_seen}, {7'h00, exp_to});
    endtask
    // pin combinations watched every cycle
    always @(negedge clk) begin
        cycles++;
        if (rst_n && we_n === 1'b0) begin
            check({5'h00, ce_n, oe_n, doe}, 8'h03);
        end
        if (rst_n && oe_n === 1'b0) begin
            check({5'h00, ce_n, we_n, doe}, 8'h02);
        end
        if (cycles > 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        logic [18:0] a;
        void'($urandom(75));
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        foreach (CORNER[i]) rd_chk(CORNER[i]);
        repeat (10) rd_chk(19'($urandom));
        $display("test array_read done");
        op(flash_host_pkg::OP_AUTOSEL, 19'($urandom), 8'h00);
        check({7'h00, as_act}, 8'h01);
        repeat (2) begin
            op(flash_host_pkg::OP_ID_MAKER, 19'($urandom), 8'h00);
            check(got, MAKER);
            op(flash_host_pkg::OP_ID_PART, 19'($urandom), 8'h00);
            check(got, PART);
        end
        for (int s = 0; s < 8; s++) begin
            a = {3'(s), 16'($urandom)};
            op(flash_host_pkg::OP_ID_PROT, a, 8'h00);
            check(got, {7'h00, PROT[s]});
        end
        a = 19'($urandom);
        op(flash_host_pkg::OP_READ, {a[18:8], 8'h01}, 8'h00);
        check(got, PART);
        $display("test autoselect done");
        op(flash_host_pkg::OP_RESET, 19'($urandom), 8'h00);
        check({6'h00, as_act, to_seen}, 8'h00);
        exp_to = 1'b0;
        rd_chk(19'h0_0100);
        $display("test reset done");
        wr(flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA);
        wr(19'($urandom), flash_host_pkg::RESET_CMD);
        wr(flash_host_pkg::UNLOCK2_ADDR, flash_host_pkg::UNLOCK2_DATA);
        wr(flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::AUTOSEL_CMD);
        rd_chk(19'h3_0400);
        unl(8'h12);
        wr(flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::AUTOSEL_CMD);
        rd_chk(19'h3_0400);
        unl(flash_host_pkg::AUTOSEL_CMD);
        op(flash_host_pkg::OP_READ, 19'h3_0400, 8'h00);
        check(got, MAKER);
        op(flash_host_pkg::OP_RESET, 19'($urandom), 8'h00);
        rd_chk(19'h3_0400);
        $display("test command_sequence done");
        tally_and_finish();
    end
endmodule // flash_host_test
`default_nettype wire
